/* File: common/apg_params.svh */
// Register indices, field positions, reset values and widths
`ifndef APG_PARAMS_SVH
`define APG_PARAMS_SVH

`define APG_IDX_W 8
`define APG_IDX_CFG3 8'h03
`define APG_IDX_PDN 8'h18
`define APG_IDX_ODD 8'h19
`define APG_IDX_EVEN 8'h1a
`define APG_IDX_STAT 8'h1f

`define APG_REG_W 16
`define APG_RST_CFG3 16'h0000
`define APG_RST_PDN 16'h0000
`define APG_RST_CORR 16'h0000

`define APG_DIG_MSB 15
`define APG_DIG_LSB 12
`define APG_LINE_MSB 11
`define APG_LINE_LSB 8
`define APG_ANA_MSB 7
`define APG_ANA_LSB 4
`define APG_FLIP_MSB 3
`define APG_FLIP_LSB 0

`define APG_GAIN_MSB 15
`define APG_GAIN_LSB 11
`define APG_RSVD_BIT 10
`define APG_OFS_MSB 9
`define APG_OFS_LSB 0

`define APG_GAIN_EN_BIT 12
`define APG_OFS_EN_BIT 8
`define APG_CFG3_MASK 16'h1100

`define APG_UNITY 16'h1000
`define APG_GAIN_SHIFT 12

`define APG_RESP_OKAY 2'h0
`define APG_RESP_SLVERR 2'h2

`endif

/* File: common/apg_pkg.sv */
// Types shared by the register bank and the correction stage
package apg_pkg;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } apg_wr_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } apg_rd_e;

  typedef logic [4:0] apg_gain_t;
  typedef logic [9:0] apg_ofs_t;

endpackage : apg_pkg

/* File: common/apg_corr_if.sv */
// Correction settings passed from the register bank to the sample path
`timescale 1ns/100ps
interface apg_corr_if;
  apg_pkg::apg_gain_t gainOdd;
  apg_pkg::apg_ofs_t offsetOdd;
  apg_pkg::apg_gain_t gainEven;
  apg_pkg::apg_ofs_t offsetEven;
  logic gainEnable;
  logic offsetEnable;

  modport cfg (
    output gainOdd,
    output offsetOdd,
    output gainEven,
    output offsetEven,
    output gainEnable,
    output offsetEnable
  );

  modport corr (
    input gainOdd,
    input offsetOdd,
    input gainEven,
    input offsetEven,
    input gainEnable,
    input offsetEnable
  );
endinterface : apg_corr_if

/* File: logic/apg_corr.sv */
// Offset and gain correction of the converter 5 sample stream
`timescale 1ns/100ps
`include "apg_params.svh"
module apg_corr #(
  parameter int SAMPLE_W = 14
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  apg_corr_if.corr cfg,
  input wire logic [SAMPLE_W-1:0] sampleIn,
  input wire logic sampleValid,
  input wire logic sampleOdd,
  output logic [SAMPLE_W-1:0] sampleOut,
  output logic sampleOutValid,
  output logic sampleOutOdd
);

  if (SAMPLE_W != 14)
  begin : gBadWidth
    $error("apg_corr serves 14-bit samples only");
  end

  // Gain per 0.2 dB step in Q4.12, 10^(N/100)
  localparam logic [15:0] GAIN_LUT [32] = '{
    16'h1000, 16'h105f, 16'h10c1, 16'h1125, 16'h118b, 16'h11f4,
    16'h125f, 16'h12cc, 16'h133c, 16'h13af, 16'h1425, 16'h149d,
    16'h1518, 16'h1595, 16'h1616, 16'h169a, 16'h1720, 16'h17aa,
    16'h1838, 16'h18c8, 16'h195c, 16'h19f3, 16'h1a8e, 16'h1b2c,
    16'h1bce, 16'h1c74, 16'h1d1d, 16'h1dcb, 16'h1e7d, 16'h1f33,
    16'h1fed, 16'h20ab
  };

  //////////////////////////////////////////////////////////////////////
  logic signed [15:0] stageVal;
  logic [15:0] stageGain;
  logic stageValid;
  logic stageOdd;
  logic signed [15:0] next_stageVal;
  logic [15:0] next_stageGain;
  logic signed [31:0] product;
  logic signed [19:0] scaled;
  logic [SAMPLE_W-1:0] next_sampleOut;

  always_comb
  begin
    apg_pkg::apg_gain_t g;
    apg_pkg::apg_ofs_t o;
    g = sampleOdd ? cfg.gainOdd : cfg.gainEven;
    o = sampleOdd ? cfg.offsetOdd : cfg.offsetEven;
    next_stageVal = 16'(signed'(sampleIn));
    if (cfg.offsetEnable)
      next_stageVal = next_stageVal - 16'(signed'(o));
    next_stageGain = cfg.gainEnable ? GAIN_LUT[g] : `APG_UNITY;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stageVal <= 16'sh0000;
      stageGain <= `APG_UNITY;
      stageValid <= 1'b0;
      stageOdd <= 1'b0;
    end
    else
    begin
      stageValid <= sampleValid;
      if (sampleValid)
      begin
        stageVal <= next_stageVal;
        stageGain <= next_stageGain;
        stageOdd <= sampleOdd;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Saturate rather than wrap, a wrapped sample is a full-scale glitch
  assign product = stageVal * signed'({1'b0, stageGain[14:0]});
  assign scaled = product[`APG_GAIN_SHIFT+19:`APG_GAIN_SHIFT];

  always_comb
  begin
    if (scaled > 20'sh01fff)
      next_sampleOut = 14'h1fff;
    else if (scaled < -20'sh02000)
      next_sampleOut = 14'h2000;
    else
      next_sampleOut = scaled[SAMPLE_W-1:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sampleOut <= '0;
      sampleOutValid <= 1'b0;
      sampleOutOdd <= 1'b0;
    end
    else
    begin
      sampleOutValid <= stageValid;
      if (stageValid)
      begin
        sampleOut <= next_sampleOut;
        sampleOutOdd <= stageOdd;
      end
    end
  end

endmodule : apg_corr

/* File: logic/apg_regs.sv */
// Power-down, line inversion and correction register bank
// Behaviour
// - Digital sleep bits 15..12 power down converters 4..1 digital blocks.
// - Line sleep bits 11..8 power down serial output lines 4..1.
// - Analog sleep bits 7..4 power down converters 4..1 analog blocks.
// - Flip bits 3..0 invert converter data on output lines 4..1.
// - Inversion never touches a line while it carries a test pattern.
// - All sleep and flip bits reset to zero, everything on.
// - Gain field 15..11 sets gain to field value times 0.2 dB.
// - Programmed gains act only while the global gain enable is set.
// - Offsets are subtracted only while the global offset enable is set.
// - Offset field 9..0 is signed, LSB equal to one 14-bit LSB.
// - Conv5_odd_gain_offset corrects odd samples of converter 5.
// - Conv5_even_gain_offset corrects even samples of converter 5.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`include "apg_params.svh"
module apg_regs #(
  parameter int ADDR_W = 12,
  parameter int LINES = 4,
  parameter int SAMPLE_W = 14
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LINES-1:0][SAMPLE_W-1:0] lineData,
  input wire logic [LINES-1:0] lineTestPattern,
  output logic [LINES-1:0][SAMPLE_W-1:0] lineOut,
  output logic [LINES-1:0] lineActive,
  output logic [3:0] convDigitalSleep,
  output logic [3:0] convAnalogSleep,
  input wire logic [SAMPLE_W-1:0] conv5Sample,
  input wire logic conv5Valid,
  input wire logic conv5Odd,
  output logic [SAMPLE_W-1:0] conv5Corrected,
  output logic conv5CorrectedValid,
  output logic conv5CorrectedOdd
);

  if (LINES != 4 || ADDR_W <= `APG_IDX_W + 2)
  begin : gBadParams
    $error("apg_regs needs four lines and room for the register map");
  end

  //////////////////////////////////////////////////////////////////////
  logic [`APG_REG_W-1:0] powerDownCtrl;
  logic [`APG_REG_W-1:0] conv5OddCorr;
  logic [`APG_REG_W-1:0] conv5EvenCorr;
  logic [`APG_REG_W-1:0] cfg3;
  logic [`APG_REG_W-1:0] lastCorrected;
  apg_pkg::apg_wr_e wrState;
  logic awGot;
  logic wGot;
  logic [ADDR_W-1:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;
  logic [`APG_IDX_W-1:0] wrIdx;
  logic wrHit;
  logic wrFire;
  apg_pkg::apg_rd_e rdState;
  logic [`APG_IDX_W-1:0] rdIdx;
  logic [`APG_REG_W-1:0] next_rdData;
  logic next_rdHit;

  apg_corr_if corrCfg ();
  //////////////////////////////////////////////////////////////////////
  // Write address and data are taken in either order and held until
  // both are in; only one write is under way at a time.
  assign wrFire = (wrState == apg_pkg::WR_IDLE) && awGot && wGot;
  assign wrIdx = awAddrHeld[`APG_IDX_W+1:2];
  always_comb
  begin
    if (awAddrHeld[1:0] != 2'b00 || awAddrHeld[ADDR_W-1:`APG_IDX_W+2] != '0)
      wrHit = 1'b0;
    else if (wrIdx == `APG_IDX_PDN || wrIdx == `APG_IDX_ODD)
      wrHit = 1'b1;
    else if (wrIdx == `APG_IDX_EVEN || wrIdx == `APG_IDX_CFG3)
      wrHit = 1'b1;
    else
      wrHit = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awGot <= 1'b0;
      awAddrHeld <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awGot <= 1'b1;
      awAddrHeld <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
      awGot <= 1'b0;
    else
      s_axi_awready <= (wrState == apg_pkg::WR_IDLE) && !awGot;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wGot <= 1'b0;
      wDataHeld <= 32'h0000_0000;
      wStrbHeld <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wGot <= 1'b1;
      wDataHeld <= s_axi_wdata;
      wStrbHeld <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
      wGot <= 1'b0;
    else
      s_axi_wready <= (wrState == apg_pkg::WR_IDLE) && !wGot;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrState <= apg_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `APG_RESP_OKAY;
    end
    else
    begin
      case (wrState)
        apg_pkg::WR_IDLE:
        begin
          if (wrFire)
          begin
            wrState <= apg_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `APG_RESP_OKAY : `APG_RESP_SLVERR;
          end
        end
        apg_pkg::WR_RESP:
        begin
          if (s_axi_bready)
          begin
            wrState <= apg_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default:
        begin
          wrState <= apg_pkg::WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Register updates; only byte lanes 0 and 1 carry storage
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction : merge

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      powerDownCtrl <= `APG_RST_PDN;
    else if (wrFire && wrHit && wrIdx == `APG_IDX_PDN)
      powerDownCtrl <= merge(powerDownCtrl, wDataHeld, wStrbHeld);
  end
  // Reserved bit 10 is stored as written and drives nothing
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      conv5OddCorr <= `APG_RST_CORR;
    else if (wrFire && wrHit && wrIdx == `APG_IDX_ODD)
      conv5OddCorr <= merge(conv5OddCorr, wDataHeld, wStrbHeld);
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      conv5EvenCorr <= `APG_RST_CORR;
    else if (wrFire && wrHit && wrIdx == `APG_IDX_EVEN)
      conv5EvenCorr <= merge(conv5EvenCorr, wDataHeld, wStrbHeld);
  end
  // Only the two enable bits exist; the rest read as zero
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cfg3 <= `APG_RST_CFG3;
    else if (wrFire && wrHit && wrIdx == `APG_IDX_CFG3)
      cfg3 <= merge(cfg3, wDataHeld, wStrbHeld) & `APG_CFG3_MASK;
  end
  //////////////////////////////////////////////////////////////////////
  // Read channel, answer one cycle after the address is taken
  assign rdIdx = s_axi_araddr[`APG_IDX_W+1:2];

  always_comb
  begin
    next_rdData = 16'h0000;
    next_rdHit = 1'b1;
    if (s_axi_araddr[1:0] != 2'b00 ||
        s_axi_araddr[ADDR_W-1:`APG_IDX_W+2] != '0)
      next_rdHit = 1'b0;
    else if (rdIdx == `APG_IDX_PDN)
      next_rdData = powerDownCtrl;
    else if (rdIdx == `APG_IDX_ODD)
      next_rdData = conv5OddCorr;
    else if (rdIdx == `APG_IDX_EVEN)
      next_rdData = conv5EvenCorr;
    else if (rdIdx == `APG_IDX_CFG3)
      next_rdData = cfg3;
    else if (rdIdx == `APG_IDX_STAT)
      next_rdData = lastCorrected;
    else
      next_rdHit = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdState <= apg_pkg::RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `APG_RESP_OKAY;
    end
    else
    begin
      case (rdState)
        apg_pkg::RD_IDLE:
        begin
          if (s_axi_arvalid && s_axi_arready)
          begin
            rdState <= apg_pkg::RD_RESP;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, next_rdData};
            s_axi_rresp <= next_rdHit ? `APG_RESP_OKAY : `APG_RESP_SLVERR;
          end
          else
            s_axi_arready <= 1'b1;
        end
        apg_pkg::RD_RESP:
        begin
          if (s_axi_rready)
          begin
            rdState <= apg_pkg::RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default:
        begin
          rdState <= apg_pkg::RD_IDLE;
          s_axi_arready <= 1'b0;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Converter power controls; bit order runs converter 4 down to 1
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      convDigitalSleep <= 4'h0;
      convAnalogSleep <= 4'h0;
    end
    else
    begin
      convDigitalSleep <= powerDownCtrl[`APG_DIG_MSB:`APG_DIG_LSB];
      convAnalogSleep <= powerDownCtrl[`APG_ANA_MSB:`APG_ANA_LSB];
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Output lines. A sleeping line drives zeros so nothing toggles.
  genvar n;
  generate
    for (n = 0; n < LINES; n++)
    begin : gLine
      logic sleep;
      logic flip;
      assign sleep = powerDownCtrl[`APG_LINE_LSB+n];
      assign flip = powerDownCtrl[`APG_FLIP_LSB+n];
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          lineOut[n] <= '0;
          lineActive[n] <= 1'b0;
        end
        else
        begin
          lineActive[n] <= !sleep;
          if (sleep)
            lineOut[n] <= '0;
          else if (flip && !lineTestPattern[n])
            lineOut[n] <= ~lineData[n];
          else
            lineOut[n] <= lineData[n];
        end
      end
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////
  // Converter 5 correction
  assign corrCfg.gainOdd = conv5OddCorr[`APG_GAIN_MSB:`APG_GAIN_LSB];
  assign corrCfg.offsetOdd = conv5OddCorr[`APG_OFS_MSB:`APG_OFS_LSB];
  assign corrCfg.gainEven = conv5EvenCorr[`APG_GAIN_MSB:`APG_GAIN_LSB];
  assign corrCfg.offsetEven = conv5EvenCorr[`APG_OFS_MSB:`APG_OFS_LSB];
  assign corrCfg.gainEnable = cfg3[`APG_GAIN_EN_BIT];
  assign corrCfg.offsetEnable = cfg3[`APG_OFS_EN_BIT];

  apg_corr #(
    .SAMPLE_W(SAMPLE_W)
  ) uCorr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cfg(corrCfg),
    .sampleIn(conv5Sample),
    .sampleValid(conv5Valid),
    .sampleOdd(conv5Odd),
    .sampleOut(conv5Corrected),
    .sampleOutValid(conv5CorrectedValid),
    .sampleOutOdd(conv5CorrectedOdd)
  );

  // Software sees the latest corrected sample, sign-extended
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lastCorrected <= 16'h0000;
    else if (conv5CorrectedValid)
      lastCorrected <= 16'(signed'(conv5Corrected));
  end

endmodule : apg_regs

/* File: test/apg_regs_props.sv */
// Port checker for the register bank
`timescale 1ns/100ps
module apg_regs_props #(
  parameter int LINES = 4,
  parameter int SAMPLE_W = 14
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LINES-1:0][SAMPLE_W-1:0] lineData,
  input wire logic [LINES-1:0] lineTestPattern,
  input wire logic [LINES-1:0][SAMPLE_W-1:0] lineOut,
  input wire logic [LINES-1:0] lineActive,
  input wire logic [3:0] convDigitalSleep,
  input wire logic [3:0] convAnalogSleep,
  input wire logic conv5Valid,
  input wire logic conv5CorrectedValid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_both |-> ##[1:3] s_axi_bvalid)
    else $error("write answer missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  AST_RD_ANSWER: assert property (s_ar_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read answer missing");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  AST_RESET_STATE: assert property ($rose(rst_n) |->
    convDigitalSleep == 4'h0 && convAnalogSleep == 4'h0 ##1
    lineActive == 4'hF) else $error("reset state wrong");
  AST_SLEEP_ZERO: assert property (!lineActive[0] &&
    !$past(lineActive[0]) |-> lineOut[0] == '0)
    else $error("sleeping line drives data");
  AST_PATTERN_KEPT: assert property (lineActive[2] &&
    $past(lineActive[2]) && $past(lineTestPattern[2]) |->
    lineOut[2] == $past(lineData[2])) else $error("pattern altered");
  AST_FLIP_FORM: assert property (lineActive[0] &&
    $past(lineActive[0]) |-> lineOut[0] == $past(lineData[0]) ||
    lineOut[0] == ~$past(lineData[0])) else $error("line data mangled");
  AST_CORR_ANSWER: assert property (conv5Valid |->
    ##[1:3] conv5CorrectedValid) else $error("corrected sample missing");
endmodule : apg_regs_props

bind apg_regs apg_regs_props #(.LINES(LINES), .SAMPLE_W(SAMPLE_W)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .lineData(lineData),
  .lineTestPattern(lineTestPattern), .lineOut(lineOut),
  .lineActive(lineActive), .convDigitalSleep(convDigitalSleep),
  .convAnalogSleep(convAnalogSleep), .conv5Valid(conv5Valid),
  .conv5CorrectedValid(conv5CorrectedValid));

/* File: test/apg_regs_tb.sv */
// Self-checking bench of the register bank
`timescale 1ns/100ps
module apg_regs_tb;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] awAddr = 12'h000;
  logic [11:0] arAddr = 12'h000;
  logic [31:0] wData = 32'h0000_0000;
  logic awValid = 1'h0;
  logic wValid = 1'h0;
  logic bReady = 1'h0;
  logic arValid = 1'h0;
  logic rReady = 1'h0;
  logic [3:0][13:0] lData = '0;
  logic [3:0] lPat = 4'h0;
  logic [13:0] cSample = 14'h0000;
  logic cValid = 1'h0;
  logic cOdd = 1'h0;
  logic awRdy, wRdy, bValid, arRdy, rValid, cOutValid, cOutOdd;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [3:0][13:0] lOut;
  logic [3:0] lAct, dSleep, aSleep;
  logic [13:0] cOut;
  int fail_count = 0;
  int comparisons = 0;
  always #10 clk_sys = ~clk_sys;
  apg_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awRdy), .s_axi_wdata(wData),
    .s_axi_wstrb(4'h3), .s_axi_wvalid(wValid), .s_axi_wready(wRdy),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arRdy),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .lineData(lData), .lineTestPattern(lPat),
    .lineOut(lOut), .lineActive(lAct), .convDigitalSleep(dSleep),
    .convAnalogSleep(aSleep), .conv5Sample(cSample), .conv5Valid(cValid),
    .conv5Odd(cOdd), .conv5Corrected(cOut),
    .conv5CorrectedValid(cOutValid), .conv5CorrectedOdd(cOutOdd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Each channel is released on its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'h1;
    w = 1'h1;
    @(posedge clk_sys);
    awAddr <= a;
    wData <= {16'h0000, d};
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= 1'h1;
    while (aw || w)
    begin
      @(posedge clk_sys);
      if (aw && awRdy === 1'h1) aw = 1'h0;
      if (w && wRdy === 1'h1) w = 1'h0;
      awValid <= aw;
      wValid <= w;
    end
    while (bValid !== 1'h1) @(posedge clk_sys);
    bReady <= 1'h0;
    check("bresp", bResp, er);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clk_sys);
    arAddr <= a;
    arValid <= 1'h1;
    rReady <= 1'h1;
    do @(posedge clk_sys); while (arRdy !== 1'h1);
    arValid <= 1'h0;
    do @(posedge clk_sys); while (rValid !== 1'h1);
    rReady <= 1'h0;
    check("rdata", rData, ed);
    check("rresp", rResp, er);
  endtask : rd
  task automatic smp(input logic [13:0] x, input logic odd,
                     input logic [13:0] ey);
    @(posedge clk_sys);
    cSample <= x;
    cOdd <= odd;
    cValid <= 1'h1;
    @(posedge clk_sys);
    cValid <= 1'h0;
    do @(posedge clk_sys); while (cOutValid !== 1'h1);
    check("sample", cOut, ey);
    check("parity", cOutOdd, odd);
  endtask : smp
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("active", lAct, 4'hF);
    check("digital", dSleep, 4'h0);
    check("analog", aSleep, 4'h0);
    rd(12'h060, 32'h0000_0000, 2'h0);
    rd(12'h064, 32'h0000_0000, 2'h0);
    rd(12'h068, 32'h0000_0000, 2'h0);
    rd(12'h070, 32'h0000_0000, 2'h2);
    rd(12'h062, 32'h0000_0000, 2'h2);
    wr(12'h07C, 16'h1234, 2'h2);
  endtask : t_reset
  task automatic t_sleep;
    wr(12'h060, 16'hA530, 2'h0);
    repeat (2) @(posedge clk_sys);
    check("digital", dSleep, 4'hA);
    check("analog", aSleep, 4'h3);
    check("active", lAct, 4'hA);
    check("line1", lOut[0], 14'h0000);
    rd(12'h060, 32'h0000_A530, 2'h0);
  endtask : t_sleep
  task automatic t_flip;
    lData <= {14'h0444, 14'h0333, 14'h0222, 14'h0111};
    lPat <= 4'h4;
    wr(12'h060, 16'h0005, 2'h0);
    repeat (2) @(posedge clk_sys);
    check("line1", lOut[0], 14'h3EEE);
    check("line2", lOut[1], 14'h0222);
    check("line3", lOut[2], 14'h0333);
    check("line4", lOut[3], 14'h0444);
  endtask : t_flip
  // Gain 5 and offset 5 on odd, gain 31 and offset -2 on even
  task automatic t_corr;
    wr(12'h064, 16'h2805, 2'h0);
    wr(12'h068, 16'hFBFE, 2'h0);
    rd(12'h064, 32'h0000_2805, 2'h0);
    rd(12'h068, 32'h0000_FBFE, 2'h0);
    wr(12'h00C, 16'h0000, 2'h0);
    smp(14'h03ED, 1'h1, 14'h03ED);
    smp(14'h0064, 1'h0, 14'h0064);
    wr(12'h00C, 16'h0100, 2'h0);
    smp(14'h03ED, 1'h1, 14'h03E8);
    smp(14'h0064, 1'h0, 14'h0066);
    wr(12'h00C, 16'h1000, 2'h0);
    smp(14'h03ED, 1'h1, 14'h0467);
    wr(12'h00C, 16'h1100, 2'h0);
    smp(14'h03ED, 1'h1, 14'h0462);
    smp(14'h0064, 1'h0, 14'h00D0);
    smp(14'h3F9C, 1'h0, 14'h3F37);
    rd(12'h07C, 32'h0000_FF37, 2'h0);
    smp(14'h1FFF, 1'h1, 14'h1FFF);
    rd(12'h07C, 32'h0000_1FFF, 2'h0);
  endtask : t_corr
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_sleep();
    t_flip();
    t_corr();
    stop_test();
  end
  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end
endmodule : apg_regs_tb
